// ### logic/irq_aggregator_pkg.sv
// constants for the two-level interrupt aggregator
`default_nettype none
package irq_aggregator_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SYSCTL1 = 8'h03;
  localparam logic [7:0] IDX_HIBCTL = 8'h05;
  localparam logic [7:0] IDX_BLK_STAT = 8'h18;
  localparam logic [7:0] IDX_OC_STAT = 8'h1d;
  localparam logic [7:0] IDX_BLK_MASK = 8'h20;
  localparam logic [7:0] IDX_OC_MASK = 8'h25;
  localparam logic [7:0] ADDR_SYSCTL1 = 8'(IDX_SYSCTL1 * 4);
  localparam logic [7:0] ADDR_HIBCTL = 8'(IDX_HIBCTL * 4);
  localparam logic [7:0] ADDR_BLK_STAT = 8'(IDX_BLK_STAT * 4);
  localparam logic [7:0] ADDR_OC_STAT = 8'(IDX_OC_STAT * 4);
  localparam logic [7:0] ADDR_BLK_MASK = 8'(IDX_BLK_MASK * 4);
  localparam logic [7:0] ADDR_OC_MASK = 8'(IDX_OC_MASK * 4);
  // field positions
  localparam int POL_BIT = 0;
  localparam int HIB_BIT = 3;
  localparam int OC_BLK_BIT = 13;
  localparam int LS_BIT = 15;
  localparam int NUM_BLK = 14;
  // implemented first-level flags (bits 11 and 10 are reserved)
  localparam logic [13:0] BLK_VALID = 14'h33ff;
  // reset values
  localparam logic POL_RST = 1'b0;
  localparam logic HIB_RST = 1'b0;
  localparam logic [13:0] BLK_MASK_RST = 14'h3fff;
  localparam logic LS_MASK_RST = 1'b0;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage
`default_nettype wire

// ### logic/two_level_irq_aggregator.sv
// two-level interrupt aggregator with apb register slave
//
// Operation
// RULE_01 - each second-level flag stays 1 once set until its register is read.
// RULE_02 - reading a second-level register returns the flags and clears them.
// RULE_03 - each first-level flag is the OR of its unmasked second-level flags.
// RULE_04 - at default polarity the request pin is low while any flag is live.
// RULE_05 - a masked second-level flag does not feed its first-level flag.
// RULE_06 - a masked second-level flag still sets and reads back.
// RULE_07 - a masked first-level flag does not assert the request pin.
// RULE_08 - the host reads block status first, then each flagged group.
// RULE_09 - polarity bit 0 of control one: 0 active low, 1 active high.
// RULE_10 - hibernate bit 3, when 1, forces the pin inactive in hibernate.
// RULE_11 - block status holds one flag per block at the listed positions.
// RULE_12 - block status ignores writes and clears each flag on read.
// RULE_13 - block mask bits 13:0 mask when 1 and reset to 1.
// RULE_14 - limit switch flag at bit 15 sets on event rise, clears on read.
// RULE_15 - limit switch mask at bit 15 masks when 1 and resets to 0.
// RULE_16 - an event in the cycle of a clearing read keeps its flag set.
// RULE_17 - the request pin is a flip-flop held inactive during reset.
`default_nettype none
module two_level_irq_aggregator
  import irq_aggregator_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event sources
  input wire logic overcurrent_event,
  input wire logic [13:0] block_event_in,
  input wire logic hibernate_state,
  // request pin
  output logic irq_pin
);

  // the decode compares against 8-bit byte addresses
  if (ADDR_W < 8)
  begin : g_bad_width
    $error("ADDR_W must be at least 8");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic pol;
    logic hib_force;
    logic [13:0] blk_stat;
    logic [13:0] blk_mask;
    logic ls_flag;
    logic ls_mask;
    logic oc_prev;
    logic [15:0] rdata;
    logic err;
    logic irq;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic setup_rd;
  logic setup;
  logic acc;
  logic acc_rd;
  logic acc_wr;
  logic [7:0] a8;
  logic hit;
  logic oc_rise;
  logic [13:0] blk_src;
  logic [13:0] blk_clr;
  logic ls_clr;
  logic req_live;

  // ****************************************************************
  // apb phase decode
  // ****************************************************************
  // zero-wait slave: every access phase completes at once
  assign pready = 1'b1;
  assign prdata = {ZERO16, s_q.rdata};
  assign pslverr = s_q.err;
  assign irq_pin = s_q.irq;

  assign setup = psel & ~penable;
  assign setup_rd = setup & ~pwrite;
  assign acc = psel & penable;
  assign acc_rd = acc & ~pwrite;
  assign acc_wr = acc & pwrite;
  assign a8 = paddr[7:0];
  // upper address bits must be zero for a hit
  assign hit = (paddr[ADDR_W-1:0] == ADDR_W'(a8)) &&
               (a8 == ADDR_SYSCTL1 || a8 == ADDR_HIBCTL ||
                a8 == ADDR_BLK_STAT || a8 == ADDR_OC_STAT ||
                a8 == ADDR_BLK_MASK || a8 == ADDR_OC_MASK);

  // ****************************************************************
  // flag sources and clears
  // ****************************************************************
  // rising edge of the over-current event
  assign oc_rise = overcurrent_event & ~s_q.oc_prev; // RULE_14

  // first-level sources; over-current block fed by its own group
  always_comb
  begin
    blk_src = block_event_in & BLK_VALID; // RULE_11
    blk_src[OC_BLK_BIT] = s_q.ls_flag & ~s_q.ls_mask; // RULE_03 RULE_05
  end

  // a read clears only what it returned, so nothing set after
  // the setup edge is lost before the host has seen it
  assign blk_clr = (acc_rd && a8 == ADDR_BLK_STAT && hit) ?
                   s_q.rdata[13:0] : 14'h0000; // RULE_12
  assign ls_clr = acc_rd && a8 == ADDR_OC_STAT && hit &&
                  s_q.rdata[LS_BIT]; // RULE_02

  // any unmasked first-level flag, unless hibernate forces quiet
  assign req_live = (|(s_q.blk_stat & ~s_q.blk_mask)) & // RULE_07
                    ~(s_q.hib_force & hibernate_state); // RULE_10

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.oc_prev = overcurrent_event;
    // sticky, set wins over the clearing read
    s_d.ls_flag = (s_q.ls_flag & ~ls_clr) | oc_rise; // RULE_01 RULE_06 RULE_16
    s_d.blk_stat = (s_q.blk_stat & ~blk_clr) | blk_src; // RULE_03 RULE_16
    // writes take effect in the access phase
    if (acc_wr && hit)
    begin
      case (a8)
        ADDR_SYSCTL1: s_d.pol = pwdata[POL_BIT]; // RULE_09
        ADDR_HIBCTL: s_d.hib_force = pwdata[HIB_BIT]; // RULE_10
        ADDR_BLK_MASK: s_d.blk_mask = pwdata[13:0]; // RULE_13
        ADDR_OC_MASK: s_d.ls_mask = pwdata[LS_BIT]; // RULE_15
        default: s_d.pol = s_q.pol; // status registers ignore writes
      endcase
    end
    // read data captured in the setup phase
    if (setup_rd)
    begin
      s_d.rdata = ZERO16;
      case (a8)
        ADDR_SYSCTL1: s_d.rdata[POL_BIT] = s_q.pol;
        ADDR_HIBCTL: s_d.rdata[HIB_BIT] = s_q.hib_force;
        ADDR_BLK_STAT: s_d.rdata[13:0] = s_q.blk_stat; // RULE_11
        ADDR_OC_STAT: s_d.rdata[LS_BIT] = s_q.ls_flag; // RULE_06
        ADDR_BLK_MASK: s_d.rdata[13:0] = s_q.blk_mask;
        ADDR_OC_MASK: s_d.rdata[LS_BIT] = s_q.ls_mask;
        default: s_d.rdata = ZERO16;
      endcase
      if (!hit)
      begin
        s_d.rdata = ZERO16;
      end
    end
    if (setup)
    begin
      s_d.err = ~hit;
    end
    // pin level from polarity
    s_d.irq = s_q.pol ? req_live : ~req_live; // RULE_04 RULE_09 RULE_17
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // pin resets high, the inactive level of the default polarity
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.pol <= POL_RST;
      s_q.hib_force <= HIB_RST;
      s_q.blk_stat <= 14'h0000;
      s_q.blk_mask <= BLK_MASK_RST; // RULE_13
      s_q.ls_flag <= 1'b0;
      s_q.ls_mask <= LS_MASK_RST; // RULE_15
      s_q.oc_prev <= 1'b0;
      s_q.rdata <= ZERO16;
      s_q.err <= 1'b0;
      s_q.irq <= 1'b1; // RULE_17
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // second-level flag behaviour

  chk_ls_sticky: assert property ( // RULE_01
    s_q.ls_flag && !ls_clr |=> s_q.ls_flag)
    else $error("limit switch flag dropped without read");

  chk_ls_rise_sets: assert property ( // RULE_14
    overcurrent_event && !$past(overcurrent_event) |=> s_q.ls_flag)
    else $error("event rise did not set limit switch flag");

  chk_ls_read_clear: assert property ( // RULE_02
    ls_clr && !oc_rise |=> !s_q.ls_flag)
    else $error("read did not clear limit switch flag");

  chk_masked_still_sets: assert property ( // RULE_06
    s_q.ls_mask && oc_rise |=> s_q.ls_flag)
    else $error("masked flag failed to set");

  chk_masked_no_block: assert property ( // RULE_05
    s_q.ls_mask && !s_q.blk_stat[OC_BLK_BIT] &&
    !block_event_in[OC_BLK_BIT] |=> !s_q.blk_stat[OC_BLK_BIT])
    else $error("masked flag set block flag");

  chk_block_follows: assert property ( // RULE_03
    s_q.ls_flag && !s_q.ls_mask |=> s_q.blk_stat[OC_BLK_BIT])
    else $error("block flag missed unmasked source");

  // pin level against masks, polarity and hibernate
  chk_pin_idle_masked: assert property ( // RULE_07
    (s_q.blk_mask | ~s_q.blk_stat) == 14'h3fff && !s_q.pol
    |=> irq_pin)
    else $error("masked flags drove request pin");

  chk_pin_low_active: assert property ( // RULE_04
    |(s_q.blk_stat & ~s_q.blk_mask) && !s_q.pol && !s_q.hib_force
    |=> !irq_pin)
    else $error("request pin not low with live flag");

  chk_hib_quiet: assert property ( // RULE_10
    s_q.hib_force && hibernate_state |=> irq_pin == !$past(s_q.pol))
    else $error("hibernate did not force pin inactive");

  chk_set_wins: assert property ( // RULE_16
    ls_clr && oc_rise |=> s_q.ls_flag)
    else $error("event lost during clearing read");

  chk_stat_no_write: assert property ( // RULE_12
    acc_wr && a8 == ADDR_BLK_STAT |=>
    ($past(s_q.blk_stat) & ~s_q.blk_stat) == 14'h0000)
    else $error("write altered block status");

  // a read clears what it returned unless the source is still live
  chk_blk_read_clear: assert property ( // RULE_12
    acc_rd && a8 == ADDR_BLK_STAT && hit |=>
    (s_q.blk_stat & $past(blk_clr) & ~$past(blk_src)) == 14'h0000)
    else $error("block status read did not clear");

  chk_reserved_zero: assert property ( // RULE_11
    s_q.blk_stat[11:10] == 2'b00)
    else $error("reserved block flag set");

  // mask writes land at the access edge
  chk_blk_mask_write: assert property ( // RULE_13
    acc_wr && hit && a8 == ADDR_BLK_MASK |=>
    s_q.blk_mask == $past(pwdata[13:0]))
    else $error("block mask write lost");

  chk_ls_mask_write: assert property ( // RULE_15
    acc_wr && hit && a8 == ADDR_OC_MASK |=>
    s_q.ls_mask == $past(pwdata[LS_BIT]))
    else $error("limit switch mask write lost");

  // active high must mirror the low case, hibernate aside
  chk_pin_high_active: assert property ( // RULE_09
    |(s_q.blk_stat & ~s_q.blk_mask) && s_q.pol &&
    !(s_q.hib_force && hibernate_state) |=> irq_pin)
    else $error("request pin not high with live flag");

  // an unmapped address is flagged at the setup edge
  chk_err_unmapped: assert property (
    setup && !hit |=> pslverr)
    else $error("unmapped access not flagged");

  // scenarios worth seeing at least once
  cov_oc_irq: cover property (
    oc_rise ##[1:4] !irq_pin);
  cov_clear_read: cover property (
    ls_clr ##1 !s_q.ls_flag);
  cov_active_high: cover property (
    s_q.pol && irq_pin);
  cov_set_wins: cover property (
    ls_clr && oc_rise);
  cov_hib_quiet: cover property (
    s_q.hib_force && hibernate_state ##1 irq_pin == !s_q.pol);

endmodule
`default_nettype wire

// ### verification/host_request_watch.sv
// host side model: turns the request pin into a request-seen level
`default_nettype none
module host_request_watch
(
  // pin and the host's idea of its polarity
  input wire logic irq_pin,
  input wire logic active_high,
  // request as the host sees it
  output logic request_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // the host decodes the pin with the polarity it programmed
  assign request_seen = active_high ? irq_pin : ~irq_pin;
endmodule
`default_nettype wire

// ### verification/two_level_irq_aggregator_tb.sv
// self-checking bench for the two-level interrupt aggregator
`default_nettype none
module two_level_irq_aggregator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_aggregator_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic overcurrent_event = 1'b0;
  logic [13:0] block_event_in = 14'h0000;
  logic hibernate_state = 1'b0;
  logic irq_pin;
  logic active_high = 1'b0;
  logic request_seen;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  two_level_irq_aggregator two_level_irq_aggregator_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .overcurrent_event(overcurrent_event),
    .block_event_in(block_event_in), .hibernate_state(hibernate_state),
    .irq_pin(irq_pin));
  host_request_watch host_request_watch_inst (.irq_pin(irq_pin),
    .active_high(active_high), .request_seen(request_seen));
  always #2.5 pclk = ~pclk;
  // a hang is cut short well after the roughly 150 cycles needed
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures = failures + 1;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // pin settles two edges after a flag change; four is margin
  task automatic pin_chk(input logic exp);
    repeat (4) @(posedge pclk);
    chk({31'h0000_0000, request_seen}, {31'h0000_0000, exp});
  endtask
  task automatic oc_pulse();
    @(posedge pclk);
    overcurrent_event <= 1'b1;
    @(posedge pclk);
    overcurrent_event <= 1'b0;
  endtask
  task automatic reset_values();
    chk({31'h0000_0000, irq_pin}, 32'h0000_0001);
    chk({31'h0000_0000, pready}, 32'h0000_0001);
    rchk(ADDR_BLK_MASK, 32'h0000_3fff);
    rchk(ADDR_OC_MASK, 32'h0000_0000);
    rchk(ADDR_SYSCTL1, 32'h0000_0000);
    rchk(ADDR_HIBCTL, 32'h0000_0000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
  endtask
  task automatic block_masked();
    oc_pulse();
    pin_chk(1'b0);
    rchk(ADDR_OC_STAT, 32'h0000_8000);
    rchk(ADDR_OC_STAT, 32'h0000_0000);
    rchk(ADDR_BLK_STAT, 32'h0000_2000);
    rchk(ADDR_BLK_STAT, 32'h0000_0000);
  endtask
  task automatic oc_request();
    apb(1'b1, ADDR_BLK_MASK, 32'h0000_1fff);
    oc_pulse();
    pin_chk(1'b1);
    repeat (20) @(posedge pclk);
    apb(1'b1, ADDR_BLK_STAT, 32'h0000_0000);
    rchk(ADDR_BLK_STAT, 32'h0000_2000);
    rchk(ADDR_OC_STAT, 32'h0000_8000);
    rchk(ADDR_OC_STAT, 32'h0000_0000);
    rchk(ADDR_BLK_STAT, 32'h0000_2000);
    rchk(ADDR_BLK_STAT, 32'h0000_0000);
    pin_chk(1'b0);
  endtask
  task automatic flag_masked();
    apb(1'b1, ADDR_OC_MASK, 32'h0000_8000);
    block_event_in <= 14'h0c00;
    oc_pulse();
    pin_chk(1'b0);
    rchk(ADDR_BLK_STAT, 32'h0000_0000);
    rchk(ADDR_OC_STAT, 32'h0000_8000);
  endtask
  // event rises at the very edge whose read clears the flag
  task automatic set_wins();
    oc_pulse();
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= 1'b0;
    paddr <= ADDR_OC_STAT;
    @(posedge pclk);
    penable <= 1'b1;
    overcurrent_event <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    chk(prdata, 32'h0000_8000);
    psel <= 1'b0;
    penable <= 1'b0;
    overcurrent_event <= 1'b0;
    rchk(ADDR_OC_STAT, 32'h0000_8000);
    rchk(ADDR_OC_STAT, 32'h0000_0000);
  endtask
  // active-high pin, a wakeup source, then the hibernate force
  task automatic pol_hib();
    apb(1'b1, ADDR_SYSCTL1, 32'h0000_0001);
    active_high <= 1'b1;
    apb(1'b1, ADDR_BLK_MASK, 32'h0000_3ffe);
    pin_chk(1'b0);
    block_event_in <= 14'h0001;
    pin_chk(1'b1);
    chk({31'h0000_0000, irq_pin}, 32'h0000_0001);
    hibernate_state <= 1'b1;
    pin_chk(1'b1);
    apb(1'b1, ADDR_HIBCTL, 32'h0000_0008);
    pin_chk(1'b0);
    hibernate_state <= 1'b0;
    pin_chk(1'b1);
    block_event_in <= 14'h0000;
    rchk(ADDR_BLK_STAT, 32'h0000_0001);
    rchk(ADDR_BLK_STAT, 32'h0000_0000);
    pin_chk(1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    block_masked();
    oc_request();
    flag_masked();
    set_wins();
    pol_hib();
    test_done();
  end
endmodule
`default_nettype wire
